// ===== core/gscr_regs.vh
// register offsets, flag positions and timing constants of the gauge status block
`ifndef GSCR_REGS_VH
`define GSCR_REGS_VH
`define GSCR_ADDR_FLAGS    7'h0A
`define GSCR_ADDR_RELATIVE_CHARGE_PERCENT     7'h0B
`define GSCR_ADDR_NOMCAP   7'h0C
`define GSCR_ADDR_LMD      7'h0E
`define GSCR_ADDR_COMPCAP  7'h10
`define GSCR_ADDR_FCOMP    7'h12
`define GSCR_ADDR_AVGI     7'h14
`define GSCR_ADDR_TTE      7'h16
`define GSCR_ADDR_TTF      7'h18
`define GSCR_ADDR_STBY     7'h1A
`define GSCR_BIT_CHG       7
`define GSCR_BIT_NO_ACTIVITY_FLAG     6
`define GSCR_BIT_TAPER     5
`define GSCR_BIT_DOUBT     4
`define GSCR_BIT_CAL       3
`define GSCR_BIT_VALID     2
`define GSCR_BIT_FIRST_END_VOLTAGE_FLAG      1
`define GSCR_BIT_FINAL_END_VOLTAGE_FLAG      0
`define GSCR_FLAGS_RESET   8'h10
`define GSCR_TAPER_MIN_AI  16'h0008
`define GSCR_TAPER_COUNT   3'h4
`define GSCR_DOUBT_CYCLES  6'h20
`define GSCR_PERCENT       8'h64
`define GSCR_MINUTES       16'h003C
`define GSCR_SAMPLE_MS     5120
`define GSCR_CLK_KHZ       40000
`endif

// ===== core/gscr_top.v
// read-only status and capacity register block of a single-cell charge gauge
//
// Function
// [RULE1] charge flag bit 7 set while charging, cleared otherwise and on reset
// [RULE2] no-activity flag bit 6 set while sense voltage below magnitude filter
// [RULE3] taper flag after four qualifying averages; disqualified when average below 8
// [RULE4] doubt flag set on full reset or 32 cycle increments; cleared on learning; the code keeps it set when learning meets a cycle count of 32 or more
// [RULE5] calibration flag bit 3 follows running offset calibration; cleared on reset
// [RULE6] valid discharge flag set when learning requirements met; cleared on disqualify
// [RULE7] first end-voltage flag bit 1; rising edge with valid discharge updates capacity
// [RULE8] final end-voltage flag bit 0 set at low voltage, cleared when charging
// [RULE9] relative charge percent is 100 times nominal over learned capacity
// [RULE10] nominal capacity rises when charging above final threshold, falls discharging
// [RULE11] nominal capacity cleared on reset only when memory corruption found
// [RULE12] learning qualifies only from full charge to first end voltage, valid throughout
// [RULE13] learned capacity loads discharged charge plus 1/16 design plus compensation
// [RULE14] compensated capacity is nominal minus reduction, never rises unless charging
// [RULE15] after load drop compensated capacity holds until difference matches reduction
// [RULE16] full compensated capacity is learned minus reduction, equal while charging
// [RULE17] average current is magnitude averaged over 5.12 s in sensor counts
// [RULE18] time to empty is 60 times compensated capacity over average current
// [RULE19] time to full is 90 times learned minus nominal over average current
// [RULE20] standby current starts at initial value, filtered 15/16 old plus 1/16
// [RULE21] host reads charge flag with average current to learn its sign
// [RULE22] host only reads these registers
// [RULE23] writes to these addresses are ignored
`timescale 1ns/1ps
`include "gscr_regs.vh"

module gscr_top #(
  parameter integer SAMPLE_CYCLES = `GSCR_SAMPLE_MS * (`GSCR_CLK_KHZ / 1000) * 1000
)(
  input  wire        clock,
  input  wire        nrst,
  input  wire        clk_en,
  input  wire        full_reset,
  input  wire        ram_corrupt,
  input  wire        charge_pin,
  input  wire        discharge_pin,
  input  wire [15:0] count_delta,
  input  wire [15:0] current_mag,
  input  wire [15:0] battery_mv,
  input  wire [15:0] final_edv_mv,
  input  wire [15:0] first_edv_mv,
  input  wire [15:0] taper_mv,
  input  wire [15:0] magnitude_filter_threshold,
  input  wire [15:0] taper_limit,
  input  wire [15:0] design_capacity,
  input  wire [15:0] comp_reduction,
  input  wire [15:0] initial_standby,
  input  wire        cal_running,
  input  wire        cycle_inc,
  input  wire        disqualify,
  input  wire        learn_ok,
  input  wire [6:0]  reg_addr,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output reg  [7:0]  status_flags,
  output reg         learn_update
);

  // pin-sourced levels pass a two-stage synchroniser first
  reg  [1:0]  chg_s_q;
  reg  [1:0]  dsg_s_q;
  reg  [1:0]  cal_s_q;
  wire        charging = chg_s_q[1];
  wire        discharging = dsg_s_q[1];

  reg  [7:0]  flags_q;
  reg  [15:0] nomcap_q;
  reg  [15:0] lmd_q;
  reg  [15:0] compcap_q;
  reg  [15:0] fcomp_q;
  reg  [15:0] avgi_q;
  reg  [15:0] tte_q;
  reg  [15:0] ttf_q;
  reg  [15:0] stby_q;
  reg  [7:0]  relative_charge_percent_q;
  reg  [15:0] removed_q;
  reg  [2:0]  taper_cnt_q;
  reg  [5:0]  cycles_q;
  reg  [31:0] tick_q;
  reg  [47:0] acc_q;
  reg         was_full_q;
  reg         boot_q;

  wire        tick = (tick_q == SAMPLE_CYCLES - 1);
  wire        first_end_voltage_flag_now = (battery_mv <= first_edv_mv) && !charging;
  wire        final_end_voltage_flag_now = (battery_mv <= final_edv_mv) && !charging;
  wire        first_end_voltage_flag_rise = first_end_voltage_flag_now && !flags_q[`GSCR_BIT_FIRST_END_VOLTAGE_FLAG];
  wire        do_learn = first_end_voltage_flag_rise && flags_q[`GSCR_BIT_VALID] && was_full_q;
  wire [15:0] comp_now = (nomcap_q > comp_reduction) ? nomcap_q - comp_reduction : 16'h0000;
  wire [15:0] fcomp_now = (lmd_q > comp_reduction) ? lmd_q - comp_reduction : 16'h0000;
  // the window sum includes the tick cycle, so each window holds SAMPLE_CYCLES samples
  wire [47:0] acc_next = acc_q + {32'h00000000, current_mag};
  wire [47:0] avg_full = acc_next / SAMPLE_CYCLES;
  wire [15:0] avg_new = avg_full[15:0];
  wire [15:0] avg_div = (avgi_q == 16'h0000) ? 16'h0001 : avgi_q;
  wire [15:0] lmd_div = (lmd_q == 16'h0000) ? 16'h0001 : lmd_q;
  wire [31:0] relative_charge_percent_full = ({16'h0000, nomcap_q} * {24'h000000, `GSCR_PERCENT}) / {16'h0000, lmd_div};
  wire [31:0] tte_full = ({16'h0000, compcap_q} * {16'h0000, `GSCR_MINUTES}) / {16'h0000, avg_div};
  wire [15:0] gap = (lmd_q > nomcap_q) ? lmd_q - nomcap_q : 16'h0000;
  wire [31:0] ttf_full = ({16'h0000, gap} * 32'h0000005A) / {16'h0000, avg_div};
  wire [15:0] lmd_new = removed_q + {4'h0, design_capacity[15:4]} + comp_reduction;
  wire [19:0] stby_sum = {4'h0, stby_q} * 20'h0000F + {4'h0, avgi_q};
  wire [16:0] stby_lim = {initial_standby, 1'b0};

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      chg_s_q <= 2'h0;
      dsg_s_q <= 2'h0;
      cal_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      chg_s_q <= {chg_s_q[0], charge_pin};
      dsg_s_q <= {dsg_s_q[0], discharge_pin};
      cal_s_q <= {cal_s_q[0], cal_running};
    end
  end

  // sample timer and 5.12 s window accumulator of current magnitude
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      tick_q <= 32'h00000000;
      acc_q <= 48'h000000000000;
      avgi_q <= 16'h0000;
    end
    else if (clk_en)
    begin
      tick_q <= tick ? 32'h00000000 : tick_q + 32'h00000001;
      if (tick)
      begin
        avgi_q <= avg_new; // RULE17
        acc_q <= 48'h000000000000;
      end
      else
        acc_q <= acc_next;
    end
  end

  // flags; the doubt flag and capacity survive a plain reset
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      // doubt flag kept over a plain reset
      flags_q <= {3'b000, flags_q[`GSCR_BIT_DOUBT], 4'h0}; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
      taper_cnt_q <= 3'h0;
      boot_q <= 1'b1;
    end
    else if (clk_en)
    begin
      boot_q <= 1'b0;
      flags_q[`GSCR_BIT_CHG] <= charging; // RULE1
      flags_q[`GSCR_BIT_NO_ACTIVITY_FLAG] <= (current_mag < magnitude_filter_threshold); // RULE2
      flags_q[`GSCR_BIT_CAL] <= cal_s_q[1]; // RULE5
      flags_q[`GSCR_BIT_FIRST_END_VOLTAGE_FLAG] <= first_end_voltage_flag_now; // RULE7
      flags_q[`GSCR_BIT_FINAL_END_VOLTAGE_FLAG] <= final_end_voltage_flag_now; // RULE8
      if (tick)
      begin
        if (charging && avgi_q >= `GSCR_TAPER_MIN_AI && avgi_q < taper_limit &&
            battery_mv >= taper_mv) // RULE3
        begin
          if (taper_cnt_q != `GSCR_TAPER_COUNT)
            taper_cnt_q <= taper_cnt_q + 3'h1;
        end
        else
          taper_cnt_q <= 3'h0;
      end
      flags_q[`GSCR_BIT_TAPER] <= (taper_cnt_q == `GSCR_TAPER_COUNT); // RULE3
      if (do_learn || disqualify || charging)
        flags_q[`GSCR_BIT_VALID] <= 1'b0; // RULE6
      else if (learn_ok && was_full_q)
        flags_q[`GSCR_BIT_VALID] <= 1'b1; // RULE6
      if (full_reset || boot_q && ram_corrupt || cycles_q >= `GSCR_DOUBT_CYCLES)
        flags_q[`GSCR_BIT_DOUBT] <= 1'b1; // RULE4
      else if (do_learn)
        flags_q[`GSCR_BIT_DOUBT] <= 1'b0; // RULE4
    end
  end

  // capacity bookkeeping; nominal and learned capacity kept over reset, nominal cleared when memory is bad
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      learn_update <= 1'b0;
      cycles_q <= 6'h00;
      was_full_q <= 1'b0;
      removed_q <= 16'h0000;
      if (ram_corrupt)
        nomcap_q <= 16'h0000; // RULE11
    end
    else if (clk_en)
    begin
      learn_update <= do_learn; // RULE13
      if (full_reset)
      begin
        nomcap_q <= 16'h0000;
        lmd_q <= design_capacity;
        cycles_q <= 6'h00;
      end
      else
      begin
        if (charging && battery_mv > final_edv_mv)
          nomcap_q <= (nomcap_q + count_delta > lmd_q) ? lmd_q : nomcap_q + count_delta; // RULE10
        else if (discharging)
          nomcap_q <= (nomcap_q > count_delta) ? nomcap_q - count_delta : 16'h0000; // RULE10
        if (do_learn)
        begin
          lmd_q <= lmd_new; // RULE12 RULE13
          cycles_q <= 6'h00;
        end
        else if (cycle_inc && cycles_q != 6'h3F)
          cycles_q <= cycles_q + 6'h01; // RULE4
      end
      if (charging)
      begin
        was_full_q <= (nomcap_q >= lmd_q); // RULE12
        removed_q <= 16'h0000;
      end
      else if (discharging)
        removed_q <= removed_q + count_delta; // RULE12
    end
  end

  // derived values
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      compcap_q <= 16'h0000;
      fcomp_q <= 16'h0000;
      relative_charge_percent_q <= 8'h00;
      tte_q <= 16'h0000;
      ttf_q <= 16'h0000;
      stby_q <= initial_standby; // RULE20
    end
    else if (clk_en)
    begin
      if (charging)
        compcap_q <= nomcap_q; // RULE14
      else if (comp_now < compcap_q)
        compcap_q <= comp_now; // RULE14 RULE15
      fcomp_q <= charging ? lmd_q : fcomp_now; // RULE16
      relative_charge_percent_q <= relative_charge_percent_full[7:0]; // RULE9
      tte_q <= tte_full[15:0]; // RULE18
      ttf_q <= ttf_full[15:0]; // RULE19
      if (tick && avgi_q > magnitude_filter_threshold && {1'b0, avgi_q} <= stby_lim)
        stby_q <= stby_sum[19:4]; // RULE20
    end
  end

  // register read port; writes are dropped on purpose
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      status_flags <= `GSCR_FLAGS_RESET;
    end
    else if (clk_en)
    begin
      status_flags <= flags_q;
      reg_rvalid <= reg_rd && !reg_wr; // RULE23
      if (reg_rd)
        case (reg_addr)
          `GSCR_ADDR_FLAGS:         reg_rdata <= flags_q;
          `GSCR_ADDR_RELATIVE_CHARGE_PERCENT:          reg_rdata <= relative_charge_percent_q;
          `GSCR_ADDR_NOMCAP:        reg_rdata <= nomcap_q[7:0];
          `GSCR_ADDR_NOMCAP + 7'h1: reg_rdata <= nomcap_q[15:8];
          `GSCR_ADDR_LMD:           reg_rdata <= lmd_q[7:0];
          `GSCR_ADDR_LMD + 7'h1:    reg_rdata <= lmd_q[15:8];
          `GSCR_ADDR_COMPCAP:       reg_rdata <= compcap_q[7:0];
          `GSCR_ADDR_COMPCAP + 7'h1: reg_rdata <= compcap_q[15:8];
          `GSCR_ADDR_FCOMP:         reg_rdata <= fcomp_q[7:0];
          `GSCR_ADDR_FCOMP + 7'h1:  reg_rdata <= fcomp_q[15:8];
          `GSCR_ADDR_AVGI:          reg_rdata <= avgi_q[7:0];
          `GSCR_ADDR_AVGI + 7'h1:   reg_rdata <= avgi_q[15:8];
          `GSCR_ADDR_TTE:           reg_rdata <= tte_q[7:0];
          `GSCR_ADDR_TTE + 7'h1:    reg_rdata <= tte_q[15:8];
          `GSCR_ADDR_TTF:           reg_rdata <= ttf_q[7:0];
          `GSCR_ADDR_TTF + 7'h1:    reg_rdata <= ttf_q[15:8];
          `GSCR_ADDR_STBY:          reg_rdata <= stby_q[7:0];
          `GSCR_ADDR_STBY + 7'h1:   reg_rdata <= stby_q[15:8];
          default:                  reg_rdata <= 8'h00;
        endcase
    end
  end

endmodule

// ===== verif/gscr_assertions.sv
// port checker for the gauge status register block
`timescale 1ns/1ps
module gscr_checker (
  input wire        clock,
  input wire        nrst,
  input wire        clk_en,
  input wire        full_reset,
  input wire        charge_pin,
  input wire        cal_running,
  input wire [15:0] current_mag,
  input wire [15:0] magnitude_filter_threshold,
  input wire [6:0]  reg_addr,
  input wire        reg_rd,
  input wire        reg_wr,
  input wire [7:0]  reg_rdata,
  input wire        reg_rvalid,
  input wire [7:0]  status_flags
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  wire take = clk_en && reg_rd && !reg_wr;
  a_read_answered: assert property (take |=> reg_rvalid)
    else $error("read got no answer");
  a_write_ignored: assert property (clk_en && reg_wr |=> !reg_rvalid)
    else $error("write got an answer");
  a_unmapped_zero: assert property (take && reg_addr == 7'h20 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flags_reset: assert property (disable iff (1'b0) !nrst |=> status_flags == 8'h10)
    else $error("flags not at reset value");
  a_chg_follows: assert property
    ((clk_en && $stable(charge_pin))[*5] |-> status_flags[7] == charge_pin)
    else $error("charge flag wrong");
  a_cal_follows: assert property
    ((clk_en && $stable(cal_running))[*5] |-> status_flags[3] == cal_running)
    else $error("calibration flag wrong");
  a_edv_clear: assert property
    ((clk_en && charge_pin)[*5] |-> status_flags[1:0] == 2'b00)
    else $error("end voltage flags set while charging");
  a_no_activity_flag_set: assert property
    ((clk_en && current_mag < magnitude_filter_threshold)[*4] |-> status_flags[6])
    else $error("no activity flag missing");
  a_full_doubt: assert property (clk_en && full_reset |-> ##[1:3] status_flags[4])
    else $error("doubt flag not set by full reset");
  c_read: cover property (take && reg_addr == 7'h0A);
  c_charge: cover property (status_flags[7]);
  c_edv: cover property (status_flags[1:0] == 2'b11);
endmodule

bind gscr_top gscr_checker u_chk (.clock, .nrst, .clk_en, .full_reset, .charge_pin,
  .cal_running, .current_mag, .magnitude_filter_threshold, .reg_addr, .reg_rd, .reg_wr,
  .reg_rdata, .reg_rvalid, .status_flags);

// ===== verif/gscr_host.sv
// host model reading and writing the gauge registers
`timescale 1ns/1ps
module gscr_host (
  input  wire       clock,
  output reg  [6:0] reg_addr = 7'h00,
  output reg        reg_rd = 1'b0,
  output reg        reg_wr = 1'b0,
  output reg  [7:0] reg_wdata = 8'h00,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid
);
  // answer lands on the taking edge and is read at the next falling edge; missing answer returns unknown
  task rd(input [6:0] a, output [7:0] d);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  end
  endtask
  task wr(input [6:0] a, input [7:0] v);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    // stale data would hide a design that samples late
    reg_wdata = ~v;
  end
  endtask
endmodule

// ===== verif/gscr_tb_top.sv
// testbench for the gauge status register block
`timescale 1ns/1ps
`include "gscr_regs.vh"
module gscr_tb_top;
  reg        clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, full_reset = 1'b0, ram_corrupt = 1'b0;
  reg        charge_pin = 1'b0, discharge_pin = 1'b0, cal_running = 1'b0, cycle_inc = 1'b0;
  reg        disqualify = 1'b0, learn_ok = 1'b0;
  reg [15:0] count_delta = 16'h0000, current_mag = 16'h0000, battery_mv = 16'h0E00;
  reg [15:0] final_edv_mv = 16'h0C80, first_edv_mv = 16'h0D00, taper_mv = 16'h0E80;
  reg [15:0] magnitude_filter_threshold = 16'h0008, taper_limit = 16'h0004;
  reg [15:0] design_capacity = 16'h0140, comp_reduction = 16'h0000, initial_standby = 16'h0010;
  wire [6:0] reg_addr;
  wire       reg_rd, reg_wr, reg_rvalid, learn_update;
  wire [7:0] reg_wdata, reg_rdata, status_flags;
  integer    n_errors = 0, tests_run = 0;
  always #12.5 clock = ~clock;
  // short sample period keeps averaging windows within the run
  gscr_top #(.SAMPLE_CYCLES(256)) u_dut (.clock, .nrst, .clk_en, .full_reset, .ram_corrupt,
    .charge_pin, .discharge_pin, .count_delta, .current_mag, .battery_mv, .final_edv_mv,
    .first_edv_mv, .taper_mv, .magnitude_filter_threshold, .taper_limit, .design_capacity,
    .comp_reduction, .initial_standby, .cal_running, .cycle_inc, .disqualify, .learn_ok,
    .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .status_flags,
    .learn_update);
  gscr_host u_host (.clock, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid);
  task chk(input [6:0] a, input [7:0] e);
    reg [7:0] d;
  begin
    u_host.rd(a, d);
    tests_run = tests_run + 1;
    if (d !== e)
    begin
      n_errors = n_errors + 1;
      $display("Error t=%0t addr %h got %h exp %h", $time, a, d, e);
    end
  end
  endtask
  task c16(input [6:0] a, input [15:0] e);
  begin
    chk(a, e[7:0]);
    chk(a + 7'h01, e[15:8]);
  end
  endtask
  // wait out the pin synchronisers, then count n cycles
  task counts(input integer n);
  begin
    repeat (5) @(negedge clock);
    count_delta = 16'h0010;
    repeat (n) @(negedge clock);
    count_delta = 16'h0000;
    repeat (4) @(negedge clock);
  end
  endtask
  task do_reset;
  begin
    nrst = 1'b0;
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
  end
  endtask
  task final_report;
  begin
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    do_reset;
    full_reset = 1'b1;
    @(negedge clock);
    full_reset = 1'b0;
    repeat (4) @(negedge clock);
    chk(`GSCR_ADDR_FLAGS, 8'h50);
    c16(`GSCR_ADDR_NOMCAP, 16'h0000);
    u_host.wr(`GSCR_ADDR_FLAGS, 8'h00);
    u_host.wr(`GSCR_ADDR_LMD, 8'hFF);
    chk(`GSCR_ADDR_FLAGS, 8'h50);
    c16(`GSCR_ADDR_LMD, 16'h0140);
    chk(7'h20, 8'h00);
    current_mag = 16'h0040;
    charge_pin = 1'b1;
    counts(10);
    chk(`GSCR_ADDR_FLAGS, 8'h90);
    c16(`GSCR_ADDR_NOMCAP, 16'h00A0);
    chk(`GSCR_ADDR_RELATIVE_CHARGE_PERCENT, 8'h32);
    c16(`GSCR_ADDR_COMPCAP, 16'h00A0);
    c16(`GSCR_ADDR_FCOMP, 16'h0140);
    battery_mv = 16'h0C00;
    counts(3);
    c16(`GSCR_ADDR_NOMCAP, 16'h00A0);
    chk(`GSCR_ADDR_FLAGS, 8'h90);
    battery_mv = 16'h0E00;
    charge_pin = 1'b0;
    discharge_pin = 1'b1;
    counts(4);
    discharge_pin = 1'b0;
    c16(`GSCR_ADDR_NOMCAP, 16'h0060);
    chk(`GSCR_ADDR_RELATIVE_CHARGE_PERCENT, 8'h1E);
    repeat (600) @(negedge clock);
    chk(`GSCR_ADDR_FLAGS, 8'h10);
    c16(`GSCR_ADDR_AVGI, 16'h0040);
    c16(`GSCR_ADDR_TTE, 16'h005A);
    c16(`GSCR_ADDR_TTF, 16'h013B);
    c16(`GSCR_ADDR_STBY, 16'h0010);
    cal_running = 1'b1;
    repeat (5) @(negedge clock);
    chk(`GSCR_ADDR_FLAGS, 8'h18);
    cal_running = 1'b0;
    battery_mv = 16'h0C00;
    repeat (5) @(negedge clock);
    chk(`GSCR_ADDR_FLAGS, 8'h13);
    do_reset;
    chk(`GSCR_ADDR_FLAGS, 8'h13);
    c16(`GSCR_ADDR_NOMCAP, 16'h0060);
    ram_corrupt = 1'b1;
    do_reset;
    ram_corrupt = 1'b0;
    c16(`GSCR_ADDR_NOMCAP, 16'h0000);
    final_report;
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
